// *** hdl/fcd_cfg.svh ***
// fcd_cfg.svh: offsets, field positions, reset values and decode constants
// of the flash card host bus decode; definitions only, included by bare name.
//
// Overview of operation
// - wide port acknowledge low for responded io addresses
// - io byte read steers even/odd onto lower
// - io byte write captures lower lane by bit
// - io word: odd upper, even lower
// - io high-only access moves odd byte upper
// - memory byte access steers lower lane
// - memory word ignores address bit zero
// - memory high-only access moves odd byte upper
// - read strobe grounded at power-up selects direct mode
// - direct mode hides memory and configuration
// - reinsertion returns to normal card mode
// - direct mode decode, both selects invalid
// - index 1 decodes any 16-byte block
// - primary block 1F0-1F7 and 3F6-3F7
// - secondary block 170-177 and 376-377
// - drive number shares the same block
// - task file 0-7, control offsets 6,7
// - data register word, byte pairs even first
// - high-only at data offset hits error/features
// - config index picks mapping, clears on reset
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH

// configuration index values
`define FCD_CFG_MEM 6'h00
`define FCD_CFG_ANY 6'h01
`define FCD_CFG_PRI 6'h02
`define FCD_CFG_SEC 6'h03
`define FCD_CFG_RST 6'h00

// address bits 9..4 of the fixed blocks
`define FCD_PRI_TASK 6'h1F
`define FCD_SEC_TASK 6'h17
`define FCD_PRI_CTL 6'h3F
`define FCD_SEC_CTL 6'h37

// register offsets in the 16-register map
`define FCD_OFS_DATA 4'h0
`define FCD_OFS_ERR 4'h1
`define FCD_OFS_TF_LO 4'h2
`define FCD_OFS_TF_HI 4'h6
`define FCD_OFS_STAT 4'h7
`define FCD_OFS_DUP_EVEN 4'h8
`define FCD_OFS_DATA_ODD 4'h9
`define FCD_OFS_DUP_ERR 4'hD
`define FCD_OFS_ALT 4'hE
`define FCD_OFS_DRV 4'hF
`define FCD_IDE_ALT_ADDR 3'h6
`define FCD_MEM_WIN_BIT 10

`endif

// *** hdl/fcd_pkg.sv ***
// fcd_pkg: types of the flash card host bus decode.
// assumes fcd_cfg.svh for all numeric constants.
package fcd_pkg;

    // host control pins, all active low
    typedef struct packed {
        logic attr_sel_n;
        logic high_lane_sel_n;
        logic low_lane_sel_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic mem_read_strobe_n;
        logic mem_write_strobe_n;
    } fcd_pins_type;

    typedef enum logic [1:0] {
        acc_none,
        acc_lo,
        acc_word,
        acc_hi
    } fcd_width_type;

    typedef struct packed {
        logic hit;
        logic [3:0] ofs;
        fcd_width_type width;
    } fcd_dec_type;

    typedef enum logic [1:0] {
        ph_idle,
        ph_decode,
        ph_busy
    } fcd_phase_type;

endpackage : fcd_pkg

// *** hdl/fcd_host_bus_decode.sv ***
// fcd_host_bus_decode: host bus decode, lane steering and task file of the card.
// assumes host pins are synchronous to clk; the disk core supplies status,
// error and read words and consumes written words and commands.
`timescale 1ns/10ps
`default_nettype none
`include "fcd_cfg.svh"

module fcd_host_bus_decode (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // host bus pins
    input wire fcd_pkg::fcd_pins_type pins,
    input wire logic [10:0] addr,
    input wire logic [7:0] upper_data_lane_in,
    input wire logic [7:0] lower_data_lane_in,
    output logic [7:0] upper_data_lane,
    output logic [7:0] lower_data_lane,
    output logic upper_lane_oe,
    output logic lower_lane_oe,
    output logic wide_port_ack_n,
    // configuration
    input wire logic config_index_wr,
    input wire logic [5:0] config_index_wdata,
    input wire logic drive_number,
    input wire logic card_reinserted,
    output logic direct_disk_mode,
    // disk core side
    input wire logic [7:0] status_in,
    input wire logic [7:0] error_in,
    input wire logic [15:0] rd_word_in,
    output logic rd_word_pop,
    output logic wr_word_valid,
    output logic [15:0] wr_word,
    output logic command_valid,
    output logic [7:0] command_code,
    output logic [7:0] features_out,
    output logic [7:0] dev_ctl_out
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic fcd_pkg::fcd_dec_type decode_access(
        input logic direct,
        input logic [5:0] cfg,
        input fcd_pkg::fcd_pins_type p,
        input logic [10:0] a);
        fcd_pkg::fcd_dec_type d;
        logic io;
        logic mem;
        logic [5:0] tb;
        logic [5:0] cb;
        d = '0;
        io = !p.io_read_strobe_n || !p.io_write_strobe_n;
        mem = !p.mem_read_strobe_n || !p.mem_write_strobe_n;
        tb = (cfg == `FCD_CFG_PRI) ? `FCD_PRI_TASK : `FCD_SEC_TASK;
        cb = (cfg == `FCD_CFG_PRI) ? `FCD_PRI_CTL : `FCD_SEC_CTL;
        case ({p.high_lane_sel_n, p.low_lane_sel_n})
            2'b10: d.width = fcd_pkg::acc_lo;
            2'b00: d.width = fcd_pkg::acc_word;
            2'b01: d.width = fcd_pkg::acc_hi;
            default: d.width = fcd_pkg::acc_none;
        endcase
        if (direct) begin
            // only io to task file and control; no memory space at all
            if (io && d.width == fcd_pkg::acc_lo) begin
                d.hit = 1'b1;
                d.ofs = {1'b0, a[2:0]};
                if (a[2:0] == 3'h0) begin
                    d.width = fcd_pkg::acc_word;
                end
            end else if (io && d.width == fcd_pkg::acc_hi && a[2:0] == `FCD_IDE_ALT_ADDR) begin
                d.hit = 1'b1;
                d.ofs = `FCD_OFS_ALT;
                d.width = fcd_pkg::acc_lo;
            end
        end else if (io && !p.attr_sel_n) begin
            if (cfg == `FCD_CFG_ANY) begin
                d.hit = 1'b1;
                d.ofs = a[3:0];
            end else if (cfg == `FCD_CFG_PRI || cfg == `FCD_CFG_SEC) begin
                if (a[9:4] == tb && !a[3]) begin
                    d.hit = 1'b1;
                    d.ofs = {1'b0, a[2:0]};
                end else if (a[9:4] == cb && a[3:1] == 3'b011) begin
                    d.hit = 1'b1;
                    d.ofs = {3'b111, a[0]};
                end
            end
        end else if (mem && p.attr_sel_n && cfg == `FCD_CFG_MEM) begin
            d.hit = 1'b1;
            d.ofs = a[`FCD_MEM_WIN_BIT] ? {3'b100, a[0]} : a[3:0];
        end
        if (d.ofs[3:2] == 2'b10 && d.ofs[1]) begin
            d.hit = 1'b0;
        end
        if (d.ofs == 4'hC || d.width == fcd_pkg::acc_none) begin
            d.hit = 1'b0;
        end
        return d;
    endfunction : decode_access

    // duplicates fold onto their primary register
    function automatic logic [3:0] fold_ofs(input logic [3:0] o);
        case (o)
            `FCD_OFS_DUP_EVEN: fold_ofs = `FCD_OFS_DATA;
            `FCD_OFS_DUP_ERR: fold_ofs = `FCD_OFS_ERR;
            default: fold_ofs = o;
        endcase
    endfunction : fold_ofs

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fcd_pkg::fcd_phase_type phase_reg;
    fcd_pkg::fcd_pins_type lat_pins_reg;
    fcd_pkg::fcd_dec_type dec;
    logic [3:0] strb_s1_reg;
    logic [3:0] strb_s2_reg;
    logic [10:0] lat_addr_reg;
    logic [15:0] lat_data_reg;
    logic [5:0] cfg_reg;
    logic mode_taken_reg;
    logic odd_next_reg;
    logic [7:0] task_file_reg [8];
    logic is_read;
    logic lo_en;
    logic hi_en;
    logic [3:0] lo_idx;
    logic [3:0] hi_idx;
    logic act;

    // ------------------------------------------------------------
    // strobe synchroniser and access sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            strb_s1_reg <= 4'h0;
            strb_s2_reg <= 4'h0;
        end else begin
            strb_s1_reg <= ~{pins.io_read_strobe_n, pins.io_write_strobe_n,
                             pins.mem_read_strobe_n, pins.mem_write_strobe_n};
            strb_s2_reg <= strb_s1_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            phase_reg <= fcd_pkg::ph_idle;
            lat_pins_reg <= '1;
            lat_addr_reg <= 11'h000;
            lat_data_reg <= 16'h0000;
        end else begin
            case (phase_reg)
                fcd_pkg::ph_idle: begin
                    if (|strb_s2_reg) begin
                        lat_pins_reg <= pins;
                        lat_addr_reg <= addr;
                        lat_data_reg <= {upper_data_lane_in, lower_data_lane_in};
                        phase_reg <= fcd_pkg::ph_decode;
                    end
                end
                fcd_pkg::ph_decode: phase_reg <= fcd_pkg::ph_busy;
                fcd_pkg::ph_busy: begin
                    if (~|strb_s2_reg) begin
                        phase_reg <= fcd_pkg::ph_idle;
                    end
                end
                default: phase_reg <= fcd_pkg::ph_idle;
            endcase
        end
    end

    // ------------------------------------------------------------
    // mode and configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_taken_reg <= 1'b0;
            direct_disk_mode <= 1'b0;
        end else if (card_reinserted) begin
            direct_disk_mode <= 1'b0;
        end else if (!mode_taken_reg) begin
            mode_taken_reg <= 1'b1;
            direct_disk_mode <= !pins.mem_read_strobe_n;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_reg <= `FCD_CFG_RST;
        end else if (config_index_wr && !direct_disk_mode) begin
            cfg_reg <= config_index_wdata;
        end
    end

    // ------------------------------------------------------------
    // lane mapping of the latched access
    // ------------------------------------------------------------
    always_comb begin
        dec = decode_access(direct_disk_mode, cfg_reg, lat_pins_reg, lat_addr_reg);
        is_read = !lat_pins_reg.io_read_strobe_n || !lat_pins_reg.mem_read_strobe_n;
        act = phase_reg == fcd_pkg::ph_decode && dec.hit;
        lo_en = 1'b0;
        hi_en = 1'b0;
        lo_idx = `FCD_OFS_DATA;
        hi_idx = `FCD_OFS_DATA_ODD;
        case (dec.width)
            fcd_pkg::acc_lo: begin
                lo_en = 1'b1;
                lo_idx = fold_ofs(dec.ofs);
                if (lo_idx == `FCD_OFS_DATA && odd_next_reg) begin
                    lo_idx = `FCD_OFS_DATA_ODD;
                end
            end
            fcd_pkg::acc_word: begin
                lo_en = 1'b1;
                hi_en = 1'b1;
                if (dec.ofs[2:1] != 2'b00) begin
                    lo_idx = {dec.ofs[3:1], 1'b0};
                    hi_idx = {dec.ofs[3:1], 1'b1};
                end
            end
            fcd_pkg::acc_hi: begin
                hi_en = 1'b1;
                hi_idx = fold_ofs({dec.ofs[3:1], 1'b1});
            end
            default: begin
                lo_en = 1'b0;
            end
        endcase
    end

    function automatic logic [7:0] read_byte(input logic [3:0] i);
        case (i)
            `FCD_OFS_DATA: read_byte = rd_word_in[7:0];
            `FCD_OFS_DATA_ODD: read_byte = rd_word_in[15:8];
            `FCD_OFS_ERR: read_byte = error_in;
            `FCD_OFS_STAT, `FCD_OFS_ALT: read_byte = status_in;
            `FCD_OFS_DRV: read_byte = {2'b01, ~task_file_reg[6][3:0], drive_number, ~drive_number};
            default: read_byte = (i >= `FCD_OFS_TF_LO && i <= `FCD_OFS_TF_HI) ? task_file_reg[i[2:0]] : 8'h00;
        endcase
    endfunction : read_byte

    // ------------------------------------------------------------
    // read lanes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            upper_data_lane <= 8'h00;
            lower_data_lane <= 8'h00;
            upper_lane_oe <= 1'b0;
            lower_lane_oe <= 1'b0;
        end else if (act && is_read) begin
            lower_data_lane <= read_byte(lo_idx);
            upper_data_lane <= read_byte(hi_idx);
            lower_lane_oe <= lo_en;
            upper_lane_oe <= hi_en;
        end else if (phase_reg != fcd_pkg::ph_decode && ~|strb_s2_reg) begin
            upper_lane_oe <= 1'b0;
            lower_lane_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // wide port acknowledge from the live address
    // ------------------------------------------------------------
    // the acknowledge asks whether the live pins would hit as an io read
    function automatic fcd_pkg::fcd_pins_type io_probe(input fcd_pkg::fcd_pins_type p);
        fcd_pkg::fcd_pins_type q;
        q = p;
        q.io_read_strobe_n = 1'b0;
        q.mem_read_strobe_n = 1'b1;
        q.mem_write_strobe_n = 1'b1;
        return q;
    endfunction : io_probe
    fcd_pkg::fcd_dec_type ack_dec;
    always_comb begin
        ack_dec = decode_access(direct_disk_mode, cfg_reg, io_probe(pins), addr);
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wide_port_ack_n <= 1'b1;
        end else begin
            wide_port_ack_n <= !ack_dec.hit;
        end
    end

    // ------------------------------------------------------------
    // data register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            odd_next_reg <= 1'b0;
            rd_word_pop <= 1'b0;
            wr_word_valid <= 1'b0;
            wr_word <= 16'h0000;
        end else begin
            rd_word_pop <= act && is_read &&
                ((lo_en && lo_idx == `FCD_OFS_DATA_ODD) || (hi_en && hi_idx == `FCD_OFS_DATA_ODD));
            wr_word_valid <= act && !is_read &&
                ((lo_en && lo_idx == `FCD_OFS_DATA_ODD) || (hi_en && hi_idx == `FCD_OFS_DATA_ODD));
            if (act && !is_read && lo_en && lo_idx == `FCD_OFS_DATA) begin
                wr_word[7:0] <= lat_data_reg[7:0];
            end
            if (act && !is_read && lo_en && lo_idx == `FCD_OFS_DATA_ODD) begin
                wr_word[15:8] <= lat_data_reg[7:0];
            end
            if (act && !is_read && hi_en && hi_idx == `FCD_OFS_DATA_ODD) begin
                wr_word[15:8] <= lat_data_reg[15:8];
            end
            if (act && dec.width == fcd_pkg::acc_lo && fold_ofs(dec.ofs) == `FCD_OFS_DATA) begin
                odd_next_reg <= !odd_next_reg;
            end else if (act && (hi_en || lo_idx == `FCD_OFS_DATA_ODD)) begin
                odd_next_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // task file, features, command and device control
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) begin
                task_file_reg[i] <= 8'h00;
            end
            features_out <= 8'h00;
            command_code <= 8'h00;
            dev_ctl_out <= 8'h00;
            command_valid <= 1'b0;
        end else begin
            command_valid <= act && !is_read &&
                ((lo_en && lo_idx == `FCD_OFS_STAT) || (hi_en && hi_idx == `FCD_OFS_STAT));
            if (act && !is_read) begin
                for (int l = 0; l < 2; l++) begin
                    logic [3:0] ix;
                    logic [7:0] v;
                    ix = (l == 0) ? lo_idx : hi_idx;
                    v = (l == 0) ? lat_data_reg[7:0] : lat_data_reg[15:8];
                    if ((l == 0) ? lo_en : hi_en) begin
                        if (ix >= `FCD_OFS_TF_LO && ix <= `FCD_OFS_TF_HI) begin
                            task_file_reg[ix[2:0]] <= v;
                        end
                        if (ix == `FCD_OFS_ERR) begin
                            features_out <= v;
                        end
                        if (ix == `FCD_OFS_STAT) begin
                            command_code <= v;
                        end
                        if (ix == `FCD_OFS_ALT) begin
                            dev_ctl_out <= v;
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb_main @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_ack_not_in_memory_mode;
        (cfg_reg == `FCD_CFG_MEM && !direct_disk_mode && $stable(cfg_reg)) |=> wide_port_ack_n;
    endproperty
    a_ack_not_in_memory_mode: assert property (p_ack_not_in_memory_mode)
        else $error("wide port ack asserted in memory mode");

    property p_byte_read_lower_only;
        (act && is_read && dec.width == fcd_pkg::acc_lo) |=> (lower_lane_oe && !upper_lane_oe);
    endproperty
    a_byte_read_lower_only: assert property (p_byte_read_lower_only)
        else $error("byte read did not use only lower lane");

    property p_word_read_both;
        (act && is_read && dec.width == fcd_pkg::acc_word) |=> (lower_lane_oe && upper_lane_oe);
    endproperty
    a_word_read_both: assert property (p_word_read_both)
        else $error("word read did not drive both lanes");

    property p_high_read_upper_only;
        (act && is_read && dec.width == fcd_pkg::acc_hi) |=> (upper_lane_oe && !lower_lane_oe);
    endproperty
    a_high_read_upper_only: assert property (p_high_read_upper_only)
        else $error("high-only read did not use only upper lane");

    property p_mode_capture;
        $rose(mode_taken_reg) |-> (direct_disk_mode == !$past(pins.mem_read_strobe_n));
    endproperty
    a_mode_capture: assert property (p_mode_capture)
        else $error("direct mode not taken from read strobe at power-up");

    property p_reinsert_normal;
        card_reinserted |=> !direct_disk_mode;
    endproperty
    a_reinsert_normal: assert property (p_reinsert_normal)
        else $error("reinsertion left direct mode set");

    property p_direct_no_memory;
        (direct_disk_mode && phase_reg == fcd_pkg::ph_decode && lat_pins_reg.io_read_strobe_n &&
         lat_pins_reg.io_write_strobe_n) |-> !dec.hit;
    endproperty
    a_direct_no_memory: assert property (p_direct_no_memory)
        else $error("memory access decoded in direct mode");

    property p_word_read_pops;
        (act && is_read && dec.width == fcd_pkg::acc_word && dec.ofs[2:0] == 3'h0) |=> rd_word_pop ##1 !rd_word_pop;
    endproperty
    a_word_read_pops: assert property (p_word_read_pops)
        else $error("word data read did not pop exactly once");

    property p_latch_first;
        (phase_reg == fcd_pkg::ph_decode) |-> ($past(phase_reg) == fcd_pkg::ph_idle && $past(|strb_s2_reg));
    endproperty
    a_latch_first: assert property (p_latch_first)
        else $error("decode without synchronised strobe");

    property p_cfg_locked_direct;
        (direct_disk_mode && config_index_wr && !card_reinserted) |=> $stable(cfg_reg);
    endproperty
    a_cfg_locked_direct: assert property (p_cfg_locked_direct)
        else $error("configuration index changed in direct mode");

endmodule : fcd_host_bus_decode
`default_nettype wire

// *** testbench/fcd_host_model.sv ***
// fcd_host_model: host bus controller that drives the card's strobe bus.
// assumes clk from the bench; every request is held for six clocks, then released for six.
`timescale 1ns/10ps
`default_nettype none
module fcd_host_model (
    // clock
    input wire logic clk,
    // host bus
    output var fcd_pkg::fcd_pins_type pins,
    output logic [10:0] addr,
    output logic [7:0] upper_in,
    output logic [7:0] lower_in,
    input wire logic [7:0] upper_data_lane,
    input wire logic [7:0] lower_data_lane
);
    initial begin
        pins = '1;
        addr = 11'h000;
        upper_in = 8'h00;
        lower_in = 8'h00;
    end
    // read strobe level across power-up selects the mode
    task automatic hold_read(input logic v);
        pins.mem_read_strobe_n <= v;
    endtask : hold_read
    // one transfer; a word goes whole, never split; the card's acknowledge is not sampled
    task automatic access(input logic mem, input logic hi_n, input logic lo_n, input logic wr,
                          input logic [10:0] a, input logic [15:0] d, output logic [15:0] q);
        fcd_pkg::fcd_pins_type p;
        p = '1;
        p.attr_sel_n = mem;
        p.high_lane_sel_n = hi_n;
        p.low_lane_sel_n = lo_n;
        p.io_read_strobe_n = mem | wr;
        p.io_write_strobe_n = mem | !wr;
        p.mem_read_strobe_n = !mem | wr;
        p.mem_write_strobe_n = !mem | !wr;
        pins <= p;
        addr <= a;
        upper_in <= d[15:8];
        lower_in <= d[7:0];
        repeat (6) @(posedge clk);
        q = {upper_data_lane, lower_data_lane};
        pins <= '1;
        // a released bus does not keep its last value
        upper_in <= ~d[15:8];
        lower_in <= ~d[7:0];
        repeat (6) @(posedge clk);
    endtask : access
endmodule : fcd_host_model
`default_nettype wire

// *** testbench/tb_flash_card_host_bus_decode.sv ***
// tb_flash_card_host_bus_decode: register tests through the host model.
// assumes fcd_host_bus_decode and fcd_host_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_flash_card_host_bus_decode;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    fcd_pkg::fcd_pins_type pins;
    logic [10:0] addr;
    logic [7:0] uin, lin, udl, ldl, ccode, feat, dctl;
    logic uoe, loe, ack_n, cfg_wr, dn, reins, ddm, pop, wv, cv;
    logic [5:0] cfg_data;
    logic [15:0] wr_word, q;
    logic up_seen, lo_seen, ack_seen, wv_seen, pop_seen, cv_seen;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    fcd_host_model host (.clk(clk), .pins(pins), .addr(addr), .upper_in(uin), .lower_in(lin),
        .upper_data_lane(udl), .lower_data_lane(ldl));
    fcd_host_bus_decode dut (.clk(clk), .resetn(resetn), .pins(pins), .addr(addr),
        .upper_data_lane_in(uin), .lower_data_lane_in(lin), .upper_data_lane(udl), .lower_data_lane(ldl),
        .upper_lane_oe(uoe), .lower_lane_oe(loe), .wide_port_ack_n(ack_n), .config_index_wr(cfg_wr),
        .config_index_wdata(cfg_data), .drive_number(dn), .card_reinserted(reins),
        .direct_disk_mode(ddm), .status_in(8'h50), .error_in(8'hE1), .rd_word_in(16'h1234),
        .rd_word_pop(pop), .wr_word_valid(wv), .wr_word(wr_word), .command_valid(cv),
        .command_code(ccode), .features_out(feat), .dev_ctl_out(dctl));
    always @(posedge clk) begin
        if (uoe === 1'b1) up_seen <= 1'b1;
        if (loe === 1'b1) lo_seen <= 1'b1;
        if (ack_n === 1'b0) ack_seen <= 1'b1;
        if (wv === 1'b1) wv_seen <= 1'b1;
        if (pop === 1'b1) pop_seen <= 1'b1;
        if (cv === 1'b1) cv_seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic go(input logic m, input logic h, input logic l, input logic w,
                      input logic [10:0] a, input logic [15:0] d);
        {up_seen, lo_seen, ack_seen, wv_seen, pop_seen, cv_seen} = 6'h00;
        host.access(m, h, l, w, a, d, q);
    endtask : go
    task automatic set_cfg(input logic [5:0] v);
        cfg_wr <= 1'b1;
        cfg_data <= v;
        @(posedge clk);
        cfg_wr <= 1'b0;
        @(posedge clk);
    endtask : set_cfg
    initial begin
        {cfg_wr, dn, reins} = 3'h0;
        cfg_data = 6'h00;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("normal_mode", 16'h0000, {15'h0, ddm});
        set_cfg(6'h02);
        go(0, 1, 0, 1, 11'h1F2, 16'h00A5); chk("ack_seen", 16'h0001, {15'h0, ack_seen});
        go(0, 1, 0, 0, 11'h1F2, 16'h0000); chk("sector_count", 16'h00A5, {8'h00, q[7:0]});
        chk("upper_oe", 16'h0000, {15'h0, up_seen});
        go(0, 1, 0, 1, 11'h1F6, 16'h0003);
        go(0, 1, 0, 0, 11'h3F7, 16'h0000); chk("drive_address", 16'h0071, {8'h00, q[7:0]});
        go(0, 0, 0, 1, 11'h1F0, 16'hBEEF); chk("word_write", 16'hBEEF, wr_word);
        go(0, 1, 0, 1, 11'h1F0, 16'h0011);
        go(0, 1, 0, 1, 11'h1F0, 16'h0022); chk("byte_pair", 16'h2211, wr_word);
        chk("pair_done", 16'h0001, {15'h0, wv_seen});
        go(0, 0, 1, 0, 11'h1F0, 16'h0000); chk("error_upper", 16'h00E1, {8'h00, q[15:8]});
        chk("lower_floated", 16'h0000, {15'h0, lo_seen});
        go(0, 0, 1, 1, 11'h1F0, 16'h7700); chk("features", 16'h0077, {8'h00, feat});
        go(0, 1, 0, 1, 11'h1F7, 16'h00EC); chk("command", 16'h00EC, {8'h00, ccode});
        chk("command_valid", 16'h0001, {15'h0, cv_seen});
        go(0, 1, 0, 1, 11'h3F6, 16'h0002); chk("device_ctl", 16'h0002, {8'h00, dctl});
        go(0, 0, 0, 0, 11'h1F0, 16'h0000); chk("word_read", 16'h1234, q);
        chk("word_pop", 16'h0001, {15'h0, pop_seen});
        dn <= 1'b1;
        go(0, 1, 0, 0, 11'h3F7, 16'h0000); chk("drive_one", 16'h0072, {8'h00, q[7:0]});
        go(0, 1, 0, 0, 11'h100, 16'h0000); chk("unmapped_ack", 16'h0000, {15'h0, ack_seen});
        $display("primary decode done");
        set_cfg(6'h03);
        go(0, 1, 0, 1, 11'h173, 16'h003C);
        go(0, 1, 0, 0, 11'h173, 16'h0000); chk("secondary_reg", 16'h003C, {8'h00, q[7:0]});
        go(0, 1, 0, 0, 11'h1F3, 16'h0000); chk("primary_gone", 16'h0000, {15'h0, lo_seen});
        $display("secondary decode done");
        set_cfg(6'h01);
        go(0, 1, 0, 1, 11'h2A5, 16'h0066);
        go(0, 1, 0, 0, 11'h0C5, 16'h0000); chk("any_block", 16'h0066, {8'h00, q[7:0]});
        $display("contiguous decode done");
        set_cfg(6'h00);
        go(1, 1, 0, 1, 11'h003, 16'h005A);
        go(1, 1, 0, 0, 11'h003, 16'h0000); chk("mem_byte", 16'h005A, {8'h00, q[7:0]});
        go(1, 0, 0, 0, 11'h401, 16'h0000); chk("mem_word", 16'h1234, q);
        go(1, 0, 1, 0, 11'h000, 16'h0000); chk("mem_high", 16'h00E1, {8'h00, q[15:8]});
        chk("mem_low_floated", 16'h0000, {15'h0, lo_seen});
        $display("memory decode done");
        resetn <= 1'b0;
        host.hold_read(1'b0);
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        host.hold_read(1'b1);
        repeat (2) @(posedge clk);
        chk("direct_mode", 16'h0001, {15'h0, ddm});
        go(0, 1, 0, 0, 11'h000, 16'h0000); chk("direct_data", 16'h1234, q);
        go(0, 0, 1, 1, 11'h006, 16'h0004); chk("direct_ctl", 16'h0004, {8'h00, dctl});
        go(0, 0, 0, 0, 11'h001, 16'h0000); chk("direct_invalid", 16'h0000, {14'h0, up_seen, lo_seen});
        go(1, 1, 0, 0, 11'h003, 16'h0000); chk("direct_no_mem", 16'h0000, {15'h0, lo_seen});
        $display("direct mode done");
        reins <= 1'b1;
        @(posedge clk);
        reins <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reinserted", 16'h0000, {15'h0, ddm});
        $display("mode selection done");
        finish_test();
    end
endmodule : tb_flash_card_host_bus_decode
`default_nettype wire
